// file: inc/arme_consts.vh
// constants for the access-control rule match engine
`ifndef ARME_CONSTS_VH
`define ARME_CONSTS_VH
`define ARME_ADDR_CTRL0   8'h6e
`define ARME_ADDR_CTRL1   8'h6f
`define ARME_ADDR_BYTE    8'ha0
`define ARME_ENTRIES      16
`define ARME_ENTRY_W      232
`define ARME_ENTRY_BYTES  5'd29
`define ARME_PORTS        5
`define ARME_CTRL_RST     8'h00
`define ARME_F_MODE       1:0
`define ARME_F_ENSEL      3:2
`define ARME_F_SD         4
`define ARME_F_EQ         5
`define ARME_F_PC         7:6
`define ARME_F_MAC        55:8
`define ARME_F_TYPE       71:56
`define ARME_F_IP         103:72
`define ARME_F_MASK       135:104
`define ARME_F_PMAX       151:136
`define ARME_F_PMIN       167:152
`define ARME_F_SEQ        167:136
`define ARME_F_PROTO      175:168
`define ARME_F_FME        176
`define ARME_F_FLAG       182:177
`define ARME_F_TCP_FLAG_MASK       188:183
`define ARME_F_MM         190:189
`define ARME_F_RP         193:191
`define ARME_F_RPE        194
`define ARME_F_LVL        197:195
`define ARME_F_PM         199:198
`define ARME_F_COUNT      199:189
`define ARME_F_FWD        204:200
`define ARME_F_FWD_UNIT   204
`define ARME_F_FWD_ALGO   203
`define ARME_F_FRN        208:205
`define ARME_F_RSET       224:209
`define ARME_MD_OFF       2'b00
`define ARME_MD_L2        2'b01
`define ARME_MD_L3        2'b10
`define ARME_MD_L4        2'b11
`define ARME_SEL_00       2'b00
`define ARME_SEL_01       2'b01
`define ARME_SEL_10       2'b10
`define ARME_SEL_11       2'b11
`define ARME_AUTH_PASS    2'b00
`define ARME_AUTH_BLOCK   2'b01
`define ARME_AUTH_TRAP    2'b11
`define ARME_CPU_MAP      5'h10
`define ARME_CLK_MHZ      200
`define ARME_US_NS        1000
`define ARME_US_CYC       (`ARME_US_NS * `ARME_CLK_MHZ / 1000)
`define ARME_MS_US        1000
`define ARME_US_LAST      8'hc7
`define ARME_MS_LAST      10'h3e7
`define ARME_PORT_LIMIT   3'h5
`endif

// file: verilog/arme_rule_engine.v
// access-control rule table, matching, rule-set arbitration, actions and rule timers
`timescale 1ns/1ps
`default_nettype none
`include "arme_consts.vh"
module arme_rule_engine (
  input  wire         clock,
  input  wire         sys_rst,
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  input  wire [4:0]   port_acl_en,
  input  wire [9:0]   port_auth_mode,
  input  wire         pkt_valid,
  input  wire [2:0]   pkt_src_port,
  input  wire [47:0]  pkt_mac_da,
  input  wire [47:0]  pkt_mac_sa,
  input  wire [15:0]  pkt_ether_type,
  input  wire         pkt_is_ip,
  input  wire [31:0]  pkt_ip_da,
  input  wire [31:0]  pkt_ip_sa,
  input  wire [7:0]   pkt_ip_proto,
  input  wire         pkt_is_tcp,
  input  wire         pkt_is_udp,
  input  wire [15:0]  pkt_dst_port,
  input  wire [15:0]  pkt_src_l4_port,
  input  wire [31:0]  pkt_tcp_seq,
  input  wire [5:0]   pkt_tcp_flags,
  input  wire         pkt_tagged,
  input  wire [2:0]   pkt_vlan_pri,
  input  wire [2:0]   pkt_qos_pri,
  input  wire [4:0]   pkt_lut_map,
  output reg          res_valid,
  output reg          res_hit,
  output reg  [4:0]   res_forward_map,
  output reg  [2:0]   res_priority,
  output reg  [2:0]   res_vlan_pri,
  output reg  [15:0]  rule_event
);

  // shared equal or not-equal decision for the layer compares; the TCP flag compare does not use it
  function arme_eqsel;
    input eq;
    input same;
    begin
      arme_eqsel = eq ? same : ~same;
    end
  endfunction

  reg  [`ARME_ENTRY_W-1:0] rule_table [0:`ARME_ENTRIES-1];
  reg  [7:0]               ctrl0_reg;
  reg  [7:0]               ctrl1_reg;
  reg  [7:0]               us_cnt_reg;
  reg  [9:0]               ms_cnt_reg;
  reg                      us_tick_reg;
  reg                      ms_tick_reg;
  wire [3:0]               sel_entry = ctrl0_reg[3:0];
  wire [4:0]               sel_byte  = ctrl1_reg[4:0];
  // byte b of an entry covers bits 8b+7 down to 8b
  wire [7:0]               sel_bit   = {sel_byte, 3'b000};
  wire                     byte_ok   = sel_byte < `ARME_ENTRY_BYTES;
  wire                     byte_wr   = reg_wr && reg_addr == `ARME_ADDR_BYTE;
  wire                     byte_rd   = reg_rd && reg_addr == `ARME_ADDR_BYTE;
  wire                     ctrl0_wr  = reg_wr && reg_addr == `ARME_ADDR_CTRL0;
  wire                     ctrl1_wr  = reg_wr && reg_addr == `ARME_ADDR_CTRL1;
  // bytes past the entry end read as zero and are never written
  wire [7:0]               byte_rdata = byte_ok ? rule_table[sel_entry][sel_bit +: 8] : 8'h00;
  wire [15:0]              rmatch;
  wire [15:0]              set_hit;
  wire [63:0]              set_frn;
  wire [15:0]              evt;
  integer                  k;
  integer                  j;

  // indirect access: ctrl0 picks the entry, ctrl1 the byte, byte port moves data
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_reg <= `ARME_CTRL_RST;
      ctrl1_reg <= `ARME_CTRL_RST;
      reg_rdata <= 8'h00;
      for (k = 0; k < `ARME_ENTRIES; k = k + 1) begin
        rule_table[k] <= {`ARME_ENTRY_W{1'b0}};
      end
    end else begin
      if (ctrl0_wr) begin
        ctrl0_reg <= reg_wdata;
      end
      if (ctrl1_wr) begin
        ctrl1_reg <= reg_wdata;
      end else if (byte_wr || byte_rd) begin
        // auto-increment lets software stream a whole entry
        ctrl1_reg <= ctrl1_reg + 8'h01;
      end
      // a written byte reaches the matching logic at the following edge
      if (byte_wr && byte_ok) begin
        rule_table[sel_entry][sel_bit +: 8] <= reg_wdata;
      end
      // read data is registered and holds until the next read strobe
      if (reg_rd) begin
        case (reg_addr)
          `ARME_ADDR_CTRL0: reg_rdata <= ctrl0_reg;
          `ARME_ADDR_CTRL1: reg_rdata <= ctrl1_reg;
          `ARME_ADDR_BYTE:  reg_rdata <= byte_rdata;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // time base: microsecond and millisecond enable pulses
  // one divider is shared, so a timer's first unit may be short by up to one unit
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      us_cnt_reg  <= 8'h00;
      ms_cnt_reg  <= 10'h000;
      us_tick_reg <= 1'b0;
      ms_tick_reg <= 1'b0;
    end else begin
      us_tick_reg <= 1'b0;
      ms_tick_reg <= 1'b0;
      if (us_cnt_reg == `ARME_US_LAST) begin
        us_cnt_reg  <= 8'h00;
        us_tick_reg <= 1'b1;
        if (ms_cnt_reg == `ARME_MS_LAST) begin
          ms_cnt_reg  <= 10'h000;
          ms_tick_reg <= 1'b1;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 10'h001;
        end
      end else begin
        us_cnt_reg <= us_cnt_reg + 8'h01;
      end
    end
  end

  // every entry judges the same packet fields in parallel, one match bit each
  wire [47:0] pkt_mac  = pkt_mac_da;
  genvar gi;
  generate
    for (gi = 0; gi < `ARME_ENTRIES; gi = gi + 1) begin : g_rule
      wire [`ARME_ENTRY_W-1:0] e     = rule_table[gi];
      wire [1:0]  md     = e[`ARME_F_MODE];
      wire [1:0]  ens    = e[`ARME_F_ENSEL];
      wire        sd     = e[`ARME_F_SD];
      wire        eq     = e[`ARME_F_EQ];
      wire [1:0]  pc     = e[`ARME_F_PC];
      wire [47:0] mac    = sd ? pkt_mac_sa : pkt_mac;
      wire [31:0] ip     = sd ? pkt_ip_sa : pkt_ip_da;
      wire [15:0] l4p    = sd ? pkt_src_l4_port : pkt_dst_port;
      wire        mac_eq = mac == e[`ARME_F_MAC];
      wire        typ_eq = pkt_ether_type == e[`ARME_F_TYPE];
      wire        ip_eq  = ((ip ^ e[`ARME_F_IP]) & e[`ARME_F_MASK]) == 32'h0;
      wire [15:0] pmax   = e[`ARME_F_PMAX];
      wire [15:0] pmin   = e[`ARME_F_PMIN];
      wire        in_rng = l4p >= pmin && l4p <= pmax;
      wire [5:0]  tcp_flag_mask   = e[`ARME_F_TCP_FLAG_MASK];
      wire        flg_ok = !e[`ARME_F_FME] ||
                           ((pkt_tcp_flags ^ e[`ARME_F_FLAG]) & tcp_flag_mask) == 6'h00;
      // per-layer results, picked by rule_mode further down
      reg         port_raw;
      reg         l2_m;
      reg         l3_m;
      reg         l4_m;
      reg  [10:0] cnt_reg;
      reg         armed_reg;
      // count mode reuses the action bits as the count value
      wire        cnt_mode = md == `ARME_MD_L2 && ens == `ARME_SEL_00;
      wire [10:0] cval     = e[`ARME_F_COUNT];
      wire        unit_ms  = e[`ARME_F_FWD_UNIT];
      wire        tick     = unit_ms ? ms_tick_reg : us_tick_reg;
      wire        cnt_pkt  = pkt_valid && cnt_mode && mac_eq && typ_eq;
      wire        up_mode  = e[`ARME_F_FWD_ALGO];
      // a zero count value never fires, so a cleared entry stays silent
      wire        up_evt   = cnt_pkt && cval != 11'h000 && cnt_reg + 11'h001 == cval;
      // a packet on the expiry tick reloads the window and hides the event
      wire        dn_evt   = armed_reg && tick && cnt_reg == 11'h001 && !cnt_pkt;

      always @* begin
        case (pc)
          `ARME_SEL_01: port_raw = l4p == pmax || l4p == pmin;
          `ARME_SEL_10: port_raw = in_rng;
          `ARME_SEL_11: port_raw = !in_rng;
          default:      port_raw = 1'b1;
        endcase
        case (ens)
          `ARME_SEL_01: l2_m = arme_eqsel(eq, typ_eq);
          `ARME_SEL_10: l2_m = arme_eqsel(eq, mac_eq);
          `ARME_SEL_11: l2_m = arme_eqsel(eq, mac_eq && typ_eq);
          default:      l2_m = 1'b0;
        endcase
        case (ens)
          `ARME_SEL_01: l3_m = pkt_is_ip && arme_eqsel(eq, ip_eq);
          `ARME_SEL_10: l3_m = pkt_is_ip && arme_eqsel(eq, pkt_ip_sa == pkt_ip_da);
          default:      l3_m = 1'b0;
        endcase
        case (ens)
          `ARME_SEL_00: l4_m = pkt_is_ip &&
                               arme_eqsel(eq, pkt_ip_proto == e[`ARME_F_PROTO]);
          `ARME_SEL_01: l4_m = pkt_is_tcp && flg_ok &&
                               (pc == `ARME_SEL_00 || arme_eqsel(eq, port_raw));
          `ARME_SEL_10: l4_m = pkt_is_udp &&
                               (pc == `ARME_SEL_00 || arme_eqsel(eq, port_raw));
          default:      l4_m = pkt_is_tcp && flg_ok &&
                               arme_eqsel(eq, pkt_tcp_seq == e[`ARME_F_SEQ]);
        endcase
      end

      // count-mode entries feed their counter only and never join a rule set
      assign rmatch[gi] = md == `ARME_MD_L2 ? l2_m :
                          md == `ARME_MD_L3 ? l3_m :
                          md == `ARME_MD_L4 ? l4_m : 1'b0;
      assign set_hit[gi] = e[`ARME_F_RSET] != 16'h0000 &&
                           (rmatch & e[`ARME_F_RSET]) == e[`ARME_F_RSET];
      assign set_frn[gi*4 +: 4] = e[`ARME_F_FRN];
      assign evt[gi] = cnt_mode && (up_mode ? up_evt : dn_evt);

      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_reg   <= 11'h000;
          armed_reg <= 1'b0;
        end else if (!cnt_mode) begin
          cnt_reg   <= 11'h000;
          armed_reg <= 1'b0;
        end else if (up_mode) begin
          armed_reg <= 1'b0;
          if (cnt_pkt) begin
            cnt_reg <= evt[gi] ? 11'h000 : cnt_reg + 11'h001;
          end
        end else if (cnt_pkt) begin
          // each qualifying packet restarts the silence window
          cnt_reg   <= cval;
          armed_reg <= cval != 11'h000;
        end else if (armed_reg && tick) begin
          cnt_reg   <= cnt_reg - 11'h001;
          armed_reg <= cnt_reg != 11'h001;
        end
      end
    end
  endgenerate

  // arbitration: lowest first_rule_index among hit sets
  // equal indexes name the same entry, so ties need no further break
  reg       win_found;
  reg [3:0] win_idx;
  always @* begin
    win_found = 1'b0;
    win_idx   = 4'h0;
    for (j = 0; j < `ARME_ENTRIES; j = j + 1) begin
      if (set_hit[j] && (!win_found || set_frn[j*4 +: 4] < win_idx)) begin
        win_found = 1'b1;
        win_idx   = set_frn[j*4 +: 4];
      end
    end
  end

  wire [`ARME_ENTRY_W-1:0] act = rule_table[win_idx];
  wire [2:0] lvl      = act[`ARME_F_LVL];
  wire [4:0] rule_map = act[`ARME_F_FWD];
  // source ports beyond the last switch port never hit and keep their lookup result, but count entries still count them
  wire       src_ok   = pkt_src_port < `ARME_PORT_LIMIT;
  wire       acl_on   = src_ok && port_acl_en[pkt_src_port];
  wire [1:0] auth     = src_ok ? port_auth_mode[{pkt_src_port, 1'b0} +: 2] : 2'b00;
  wire       hit      = acl_on && win_found;

  // misses on ACL-enabled ports follow the port's authentication mode; mode 10 falls back to pass
  reg [4:0] map_next;
  reg [2:0] pri_next;
  always @* begin
    map_next = pkt_lut_map;
    pri_next = pkt_qos_pri;
    if (hit) begin
      case (act[`ARME_F_MM])
        `ARME_SEL_01: map_next = pkt_lut_map | rule_map;
        `ARME_SEL_10: map_next = pkt_lut_map & rule_map;
        `ARME_SEL_11: map_next = rule_map;
        default:      map_next = pkt_lut_map;
      endcase
      case (act[`ARME_F_PM])
        `ARME_SEL_01: pri_next = lvl > pkt_qos_pri ? lvl : pkt_qos_pri;
        `ARME_SEL_10: pri_next = lvl < pkt_qos_pri ? lvl : pkt_qos_pri;
        `ARME_SEL_11: pri_next = lvl;
        default:      pri_next = pkt_qos_pri;
      endcase
    end else if (acl_on) begin
      case (auth)
        `ARME_AUTH_BLOCK: map_next = 5'h00;
        `ARME_AUTH_TRAP:  map_next = `ARME_CPU_MAP;
        default:          map_next = pkt_lut_map;
      endcase
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      res_valid       <= 1'b0;
      res_hit         <= 1'b0;
      res_forward_map <= 5'h00;
      res_priority    <= 3'h0;
      res_vlan_pri    <= 3'h0;
      rule_event      <= 16'h0000;
    end else begin
      res_valid  <= pkt_valid;
      rule_event <= evt;
      // results hold between packets so the forwarding stage may sample late
      if (pkt_valid) begin
        res_hit         <= hit;
        res_forward_map <= map_next;
        res_priority    <= pri_next;
        // only tagged packets carry a priority to remark
        res_vlan_pri    <= (hit && pkt_tagged && act[`ARME_F_RPE]) ?
                           act[`ARME_F_RP] : pkt_vlan_pri;
      end
    end
  end

endmodule // arme_rule_engine
`default_nettype wire

// file: testbench/arme_rule_engine_props.sv
// property checker for the rule engine packet result ports
`timescale 1ns/1ps
`default_nettype none
`include "arme_consts.vh"
module arme_rule_engine_props (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [4:0] port_acl_en,
  input wire logic [9:0] port_auth_mode,
  input wire logic       pkt_valid,
  input wire logic [2:0] pkt_src_port,
  input wire logic [2:0] pkt_vlan_pri,
  input wire logic [2:0] pkt_qos_pri,
  input wire logic [4:0] pkt_lut_map,
  input wire logic       res_valid,
  input wire logic       res_hit,
  input wire logic [4:0] res_forward_map,
  input wire logic [2:0] res_priority,
  input wire logic [2:0] res_vlan_pri
);
  // request context kept until its result shows, so misses can be judged
  logic       en_q;
  logic [1:0] mode_q;
  logic [4:0] lut_q;
  logic [2:0] qos_q;
  logic [2:0] vlan_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_q   <= 1'b0;
      mode_q <= 2'b00;
      lut_q  <= 5'h00;
      qos_q  <= 3'h0;
      vlan_q <= 3'h0;
    end else if (pkt_valid) begin
      en_q   <= (pkt_src_port < 3'd5) && port_acl_en[pkt_src_port];
      mode_q <= port_auth_mode[{pkt_src_port, 1'b0} +: 2];
      lut_q  <= pkt_lut_map;
      qos_q  <= pkt_qos_pri;
      vlan_q <= pkt_vlan_pri;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_result_timing: assert property ((pkt_valid |=> res_valid) and (!pkt_valid |=> !res_valid))
    else $error("result pulse not one cycle after packet");
  a_off_port: assert property (res_valid && !en_q |-> !res_hit && res_forward_map == lut_q
    && res_priority == qos_q) else $error("disabled port result altered");
  a_hit_enabled: assert property (res_hit |-> en_q)
    else $error("hit on disabled port");
  a_pass_miss: assert property (res_valid && en_q && !res_hit && !mode_q[0]
    |-> res_forward_map == lut_q) else $error("pass miss map wrong");
  a_block_miss: assert property (res_valid && en_q && !res_hit && mode_q == 2'b01
    |-> res_forward_map == 5'h00) else $error("block miss not dropped");
  a_trap_miss: assert property (res_valid && en_q && !res_hit && mode_q == 2'b11
    |-> res_forward_map == `ARME_CPU_MAP) else $error("trap miss not to processor");
  a_miss_no_remark: assert property (res_valid && !res_hit
    |-> res_vlan_pri == vlan_q && res_priority == qos_q) else $error("miss changed priority");
  a_result_holds: assert property (!res_valid |-> $stable(res_hit)
    && $stable(res_forward_map) && $stable(res_priority)) else $error("result moved idle");
endmodule // arme_rule_engine_props
bind arme_rule_engine arme_rule_engine_props u_props (
  .clock(clock), .sys_rst(sys_rst), .port_acl_en(port_acl_en),
  .port_auth_mode(port_auth_mode), .pkt_valid(pkt_valid), .pkt_src_port(pkt_src_port),
  .pkt_vlan_pri(pkt_vlan_pri), .pkt_qos_pri(pkt_qos_pri), .pkt_lut_map(pkt_lut_map),
  .res_valid(res_valid), .res_hit(res_hit), .res_forward_map(res_forward_map),
  .res_priority(res_priority), .res_vlan_pri(res_vlan_pri));
`default_nettype wire

// file: testbench/arme_lookup_model.sv
// switch lookup stand-in: forwarding map and class priority per destination
`timescale 1ns/1ps
`default_nettype none
module arme_lookup_model (
  input  wire logic [47:0] mac_da,
  output logic      [4:0]  lut_map,
  output logic      [2:0]  qos_pri
);
  // a plain slice of the address keeps bench expectations easy to derive
  assign lut_map = mac_da[4:0];
  assign qos_pri = mac_da[7:5];
endmodule // arme_lookup_model
`default_nettype wire

// file: testbench/arme_rule_engine_bench.sv
// self-checking bench for the rule engine
`timescale 1ns/1ps
`default_nettype none
`include "arme_consts.vh"
module arme_rule_engine_bench;
  localparam logic [47:0] HIT_DA = 48'h001122334455;
  logic         clock = 1'b0;
  logic         sys_rst = 1'b1;
  logic [7:0]   reg_addr = 8'h00;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [4:0]   port_acl_en = 5'h1f;
  logic [2:0]   src_port = 3'd0;
  logic [9:0]   port_auth_mode = 10'h000;
  logic         pkt_valid = 1'b0;
  logic [47:0]  mac_da = 48'h0;
  logic [15:0]  ether = 16'h0800;
  logic [7:0]   reg_rdata;
  logic [4:0]   lut_map;
  logic [2:0]   qos_pri;
  logic         res_valid;
  logic         res_hit;
  logic [4:0]   res_forward_map;
  logic [2:0]   res_priority;
  logic [2:0]   res_vlan_pri;
  logic [15:0]  rule_event;
  logic [15:0]  ev;
  logic [231:0] ent;
  int           error_cnt = 0;
  int           check_count = 0;

  always #2.5 clock = ~clock;

  arme_lookup_model lut (.mac_da(mac_da), .lut_map(lut_map), .qos_pri(qos_pri));
  // spare IP, port, sequence and flag fields are slices of the address, so they change only when the address does
  arme_rule_engine dut (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_acl_en(port_acl_en),
    .port_auth_mode(port_auth_mode), .pkt_valid(pkt_valid), .pkt_src_port(src_port),
    .pkt_mac_da(mac_da), .pkt_mac_sa(~mac_da), .pkt_ether_type(ether), .pkt_is_ip(1'b1),
    .pkt_ip_da(mac_da[31:0]), .pkt_ip_sa(mac_da[47:16]), .pkt_ip_proto(mac_da[7:0]),
    .pkt_is_tcp(1'b1), .pkt_is_udp(1'b0), .pkt_dst_port(mac_da[15:0]),
    .pkt_src_l4_port(mac_da[31:16]), .pkt_tcp_seq(mac_da[39:8]),
    .pkt_tcp_flags(mac_da[5:0]), .pkt_tagged(1'b1), .pkt_vlan_pri(3'd1),
    .pkt_qos_pri(qos_pri), .pkt_lut_map(lut_map), .res_valid(res_valid), .res_hit(res_hit),
    .res_forward_map(res_forward_map), .res_priority(res_priority),
    .res_vlan_pri(res_vlan_pri), .rule_event(rule_event));

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // strobe is dropped for one cycle between accesses so it is never set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata === e, "register read");
  endtask

  task automatic put(input logic [3:0] i);
    wr(`ARME_ADDR_CTRL0, {4'h0, i});
    wr(`ARME_ADDR_CTRL1, 8'h00);
    for (int b = 0; b < 29; b++) wr(`ARME_ADDR_BYTE, ent[8*b +: 8]);
  endtask

  task automatic pkt(input logic [47:0] da, input logic h, input logic [4:0] m,
                     input logic [2:0] p, input logic [2:0] v);
    pkt_valid <= 1'b1;
    mac_da <= da;
    @(posedge clock);
    pkt_valid <= 1'b0;
    #1;
    ev = rule_event;
    chk(res_valid === 1'b1 && res_hit === h && res_forward_map === m
        && res_priority === p && res_vlan_pri === v, "packet result");
    @(posedge clock);
  endtask

  task automatic t_actions;
    logic [4:0] maps [4];
    logic [2:0] pris [4];
    maps = '{5'h15, 5'h17, 5'h04, 5'h06};
    pris = '{3'd2, 3'd6, 3'd2, 3'd6};
    ent = '0;
    ent[`ARME_F_MODE] = `ARME_MD_L2;
    ent[`ARME_F_ENSEL] = `ARME_SEL_11;
    ent[`ARME_F_EQ] = 1'b1;
    ent[`ARME_F_MAC] = HIT_DA;
    ent[`ARME_F_TYPE] = 16'h0800;
    ent[`ARME_F_RP] = 3'd5;
    ent[`ARME_F_LVL] = 3'd6;
    ent[`ARME_F_FWD] = 5'h06;
    ent[`ARME_F_RSET] = 16'h0001;
    for (int k = 0; k < 4; k++) begin
      ent[`ARME_F_PM] = 2'(k);
      ent[`ARME_F_MM] = 2'(k);
      ent[`ARME_F_RPE] = k[0];
      put(4'd0);
      pkt(HIT_DA, 1'b1, maps[k], pris[k], k[0] ? 3'd5 : 3'd1);
    end
    $display("test actions done");
  endtask

  task automatic t_regs;
    wr(`ARME_ADDR_CTRL0, 8'h00);
    wr(`ARME_ADDR_CTRL1, 8'h01);
    rd(`ARME_ADDR_BYTE, 8'h55);
    rd(`ARME_ADDR_BYTE, 8'h44);
    rd(`ARME_ADDR_CTRL1, 8'h03);
    wr(8'h71, 8'hff);
    rd(8'h71, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_count;
    ent = '0;
    ent[`ARME_F_MODE] = `ARME_MD_L2;
    ent[`ARME_F_MAC] = HIT_DA;
    ent[`ARME_F_TYPE] = 16'h0800;
    ent[`ARME_F_COUNT] = 11'd2;
    ent[`ARME_F_FWD_ALGO] = 1'b1;
    put(4'd1);
    for (int n = 0; n < 3; n++) begin
      pkt(HIT_DA, 1'b1, 5'h06, 3'd6, 3'd5);
      chk(ev === ((n == 1) ? 16'h0002 : 16'h0000), "count event");
    end
    $display("test counter done");
  endtask

  task automatic t_auth;
    logic [1:0] modes [4];
    logic [4:0] maps [4];
    modes = '{2'b00, 2'b01, 2'b11, 2'b10};
    maps = '{5'h03, 5'h00, `ARME_CPU_MAP, 5'h03};
    for (int k = 0; k < 4; k++) begin
      port_auth_mode <= {8'h00, modes[k]};
      pkt(48'h0000000000a3, 1'b0, maps[k], 3'd5, 3'd1);
    end
    port_acl_en <= 5'h1e;
    pkt(HIT_DA, 1'b0, 5'h15, 3'd2, 3'd1);
    port_acl_en <= 5'h1f;
    port_auth_mode <= 10'h004;
    src_port <= 3'd1;
    pkt(48'h0000000000a3, 1'b0, 5'h00, 3'd5, 3'd1);
    src_port <= 3'd5;
    pkt(HIT_DA, 1'b0, 5'h15, 3'd2, 3'd1);
    src_port <= 3'd0;
    port_auth_mode <= 10'h000;
    $display("test authentication done");
  endtask

  task automatic t_layers;
    ent = '0;
    ent[`ARME_F_MODE] = `ARME_MD_L3;
    ent[`ARME_F_ENSEL] = `ARME_SEL_01;
    ent[`ARME_F_IP] = 32'h99999900;
    ent[`ARME_F_MASK] = 32'hffffff00;
    ent[`ARME_F_MM] = 2'b11;
    ent[`ARME_F_FWD] = 5'h09;
    ent[`ARME_F_FRN] = 4'd2;
    ent[`ARME_F_RSET] = 16'h0004;
    put(4'd2);
    pkt(48'h0000000000a3, 1'b1, 5'h09, 3'd5, 3'd1);
    pkt(HIT_DA, 1'b1, 5'h06, 3'd6, 3'd5);
    $display("test layers done");
  endtask

  task automatic t_timer;
    int   n;
    logic got;
    got = 1'b0;
    n = 0;
    ent = '0;
    ent[`ARME_F_MODE] = `ARME_MD_L2;
    ent[`ARME_F_MAC] = HIT_DA;
    ent[`ARME_F_TYPE] = 16'h0800;
    ent[`ARME_F_COUNT] = 11'd2;
    put(4'd1);
    pkt(HIT_DA, 1'b1, 5'h06, 3'd6, 3'd5);
    chk(ev === 16'h0000, "timer load event");
    while (!got && n < 3 * `ARME_US_CYC) begin
      @(posedge clock);
      #1;
      n++;
      got = rule_event[1];
    end
    chk(got && n >= `ARME_US_CYC && n <= 2 * `ARME_US_CYC + 1, "timer expiry");
    @(posedge clock);
    #1;
    chk(rule_event === 16'h0000, "timer pulse width");
    $display("test timer done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("unexpected at %0t: run limit reached", $time);
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_actions();
    t_regs();
    t_count();
    t_auth();
    t_layers();
    t_timer();
    give_verdict();
  end
endmodule // arme_rule_engine_bench
`default_nettype wire
